//--- tgd_map.svh
`ifndef TGD_MAP_SVH
`define TGD_MAP_SVH
// Word addresses (word space, one 16-bit word per address)
`define TGD_A_FLAGS      9'h000
`define TGD_A_THRESH     9'h003
`define TGD_A_LEVELS     9'h026
`define TGD_A_ON_POINT   9'h051
`define TGD_A_OFF_POINT  9'h052
`define TGD_A_EYE_LEVEL  9'h092
`define TGD_A_TONE_COEF  9'h145
`define TGD_A_BAND_A     9'h155
`define TGD_A_BAND_B     9'h15F
`define TGD_A_TX_POWER   9'h185
`define TGD_A_DIAL_ON    9'h18C
`define TGD_A_DIAL_OFF   9'h18D
`define TGD_A_DIAL_PAUSE 9'h18E
`define TGD_A_GEN_A      9'h191
`define TGD_A_GEN_B      9'h196
`define TGD_A_LOW_LEV    9'h1A0
`define TGD_A_HIGH_LEV   9'h1A1
`define TGD_A_CONNECTION_MODE_REPORT  9'h1F0
`define TGD_A_EYE_LIMIT  9'h1F6
`define TGD_A_BAND_STAT  9'h1FC
`define TGD_A_DIAL_CTRL  9'h1FD
`define TGD_A_MODE       9'h1FE
// Mode codes
`define TGD_M_STANDBY 7'h00
`define TGD_M_TONES   7'h01
`define TGD_M_DETECT  7'h02
`define TGD_M_DIAL    7'h03
`define TGD_M_V22BIS  7'h08
`define TGD_M_V22     7'h09
`define TGD_M_B212A   7'h0B
`define TGD_M_V21     7'h10
`define TGD_M_B103    7'h11
`define TGD_M_V23TX   7'h13
`define TGD_M_V23RX   7'h14
`define TGD_M_FV29_96 7'h20
`define TGD_M_FV29_72 7'h21
// Reset values
`define TGD_D_HIGH_LEV  16'h4026
`define TGD_D_LOW_LEV   16'h2D6A
`define TGD_D_TX_POWER  16'h0288
`define TGD_D_DIAL_TIME 16'h0390
`define TGD_D_THRESH    16'h0813
`define TGD_D_ON_POINT  16'h0247
`define TGD_D_OFF_POINT 16'h0104
`define TGD_D_EYE_LIMIT 16'h0400
`define TGD_D_TONE_COEF 96'h5218_59F8_687A_6C9B_7015_72E8
`define TGD_D_BAND_COEF {160'h01AA_FEBC_01AA_7438_C7CD_00A4_0000_FF5C_7A66_C148, \
  160'h0716_0000_F8EA_6FE1_C63E_0716_F5FB_0716_7601_C774}
// Field positions
`define TGD_B_DIAL_START 8
`define TGD_B_DIAL_PULSE 4
`define TGD_B_EYE_ERR    4
// Timing
`define TGD_CLK_HZ     10000000
`define TGD_SAMPLE_HZ  9600
`define TGD_DIAL_MS    95
`define TGD_LEVEL_NS   100000
// Phase: one full cycle is 2*pi*4096
`define TGD_PH_FULL    17'd25736
`define TGD_PH_HALF    16'd12868
`define TGD_SINE_K     22'd3399610
`define TGD_EYE_SHIFT  4
`endif

//--- tgd_pkg.sv
package tgd_pkg;
  typedef enum logic [1:0] {
    TGD_IDLE  = 2'b00,
    TGD_ON    = 2'b01,
    TGD_OFF   = 2'b11,
    TGD_PAUSE = 2'b10
  } tgd_dial_e;
  typedef struct packed {
    logic [15:0] band_a;  // Band detector A power
    logic [15:0] band_b;  // Band detector B power
    logic [15:0] mse;     // Eye error sample
  } tgd_meas_s;
  typedef logic [15:0] tgd_word_t;
endpackage

//--- tgd_core.sv
`timescale 1ns/100ps
`include "tgd_map.svh"
module tgd_core import tgd_pkg::*; #(
  parameter int BAUD_SAMPLES = 8,
  parameter logic [15:0] PART_ID = 16'hA5A5  // Arbitrary value
) (
  input wire logic clock_i,            // 10 MHz clock
  input wire logic rst_i,              // Sync reset, high
  input wire logic ce_i,               // Clock enable
  input wire logic [8:0] addr_i,       // Word address
  input wire logic [15:0] wdata_i,     // Write data
  input wire logic wr_i,               // Write strobe
  input wire logic rd_i,               // Read strobe
  output logic [15:0] rdata_o,         // Read data, next cycle
  input wire tgd_meas_s meas_i,        // Receive measurements
  input wire logic [255:0] tone_lev_i, // Detector levels, n at [16n+:16]
  input wire logic meas_valid_i,       // Measurements valid pulse
  output logic signed [15:0] tx_o,     // Transmit sample
  output logic hook_break_o,           // Pulse dial break
  output logic dial_busy_o,            // Dial sequence running
  output logic eye_error_o,            // Eye error flag
  output logic sample_tick_o           // 9600 Hz tick
);
  localparam int SAMPLE_DIV = (`TGD_CLK_HZ + `TGD_SAMPLE_HZ / 2)
                              / `TGD_SAMPLE_HZ;
  localparam int DIAL_SAMPLES = `TGD_DIAL_MS * `TGD_SAMPLE_HZ / 1000;
  localparam logic [95:0] TONE_DEF = `TGD_D_TONE_COEF;
  localparam logic [319:0] BAND_DEF = `TGD_D_BAND_COEF;

  // Parabolic sine of a phase within one full cycle, Q15 result
  function automatic logic signed [15:0] tgd_sine(input logic [15:0] ph);
    logic [15:0] x;
    logic [25:0] p;
    logic [47:0] q;
    x = (ph >= `TGD_PH_HALF) ? ph - `TGD_PH_HALF : ph;
    p = 26'(x * (`TGD_PH_HALF - x));
    q = 48'(p * `TGD_SINE_K);
    tgd_sine = (ph >= `TGD_PH_HALF) ? -$signed({1'b0, q[46:32]})
                                    : $signed({1'b0, q[46:32]});
  endfunction

  // Signed value times unsigned Q15 gain
  function automatic logic signed [15:0] tgd_gain(
      input logic signed [15:0] s, input logic [15:0] g);
    logic signed [32:0] m;
    m = s * $signed({1'b0, g});
    tgd_gain = m[30:15];
  endfunction

  // Wrapping phase advance
  function automatic logic [15:0] tgd_step(input logic [15:0] ph,
                                           input logic [15:0] st);
    logic [16:0] n;
    n = {1'b0, ph} + {1'b0, st};
    if (n >= `TGD_PH_FULL) begin
      n = n - `TGD_PH_FULL;
    end
    if (n >= `TGD_PH_FULL) begin
      n = n - `TGD_PH_FULL;
    end
    tgd_step = n[15:0];
  endfunction

  logic [6:0] mode;
  logic [15:0] tone_flags, thresh, on_point, off_point, eye_level;
  logic [15:0] eye_limit, tx_power, tx_power_live, dial_on, dial_off;
  logic [15:0] dial_pause, gen_a_step, gen_b_step, low_lev, high_lev;
  logic [15:0] dial_ctrl, phase_a, phase_b, dial_cnt;
  logic [15:0] tone_levels [16];
  logic [15:0] tone_coef [16];
  logic [15:0] band_coef [20];
  logic [1:0] band_stat;
  logic [10:0] div_cnt;
  logic [7:0] baud_cnt;
  logic [3:0] pulses;
  logic eye_mode, mode_wr, dial_start, tone_gate;
  logic signed [16:0] mix;
  logic signed [33:0] scaled;
  tgd_dial_e dial_state, next_dial_state;

  // Mode write and eye-monitored modes
  assign mode_wr = wr_i && addr_i == `TGD_A_MODE;
  assign dial_start = wr_i && addr_i == `TGD_A_DIAL_CTRL
                      && wdata_i[`TGD_B_DIAL_START] && mode == `TGD_M_DIAL;
  assign eye_mode = mode == `TGD_M_V22BIS || mode == `TGD_M_V22
                    || mode == `TGD_M_B212A;

  // Sample and baud ticks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_cnt <= 11'h000;
      sample_tick_o <= 1'b0;
      baud_cnt <= 8'h00;
    end else if (ce_i) begin
      sample_tick_o <= div_cnt == 11'(SAMPLE_DIV - 1);
      div_cnt <= div_cnt == 11'(SAMPLE_DIV - 1) ? 11'h000 : div_cnt + 11'h001;
      if (sample_tick_o) begin
        baud_cnt <= baud_cnt == 8'(BAUD_SAMPLES - 1) ? 8'h00
                    : baud_cnt + 8'h01;
      end
    end
  end

  // Mode field and plain host registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode <= `TGD_M_STANDBY;
      tx_power <= `TGD_D_TX_POWER;
      gen_a_step <= 16'h0000;
      gen_b_step <= 16'h0000;
      low_lev <= `TGD_D_LOW_LEV;
      high_lev <= `TGD_D_HIGH_LEV;
      eye_limit <= `TGD_D_EYE_LIMIT;
      dial_ctrl <= 16'h0000;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `TGD_A_MODE: mode <= wdata_i[6:0];
        `TGD_A_TX_POWER: tx_power <= wdata_i;
        `TGD_A_GEN_A: gen_a_step <= wdata_i;
        `TGD_A_GEN_B: gen_b_step <= wdata_i;
        `TGD_A_LOW_LEV: low_lev <= wdata_i;
        `TGD_A_HIGH_LEV: high_lev <= wdata_i;
        `TGD_A_EYE_LIMIT: eye_limit <= wdata_i;
        `TGD_A_DIAL_CTRL: dial_ctrl <= {8'h00, wdata_i[7:0]};
        default: ;
      endcase
    end
  end

  // Coefficient memories
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        tone_coef[i] <= 16'h0000;
      end
      for (int i = 0; i < 6; i++) begin
        tone_coef[i] <= TONE_DEF[16*i +: 16];
      end
      for (int i = 0; i < 20; i++) begin
        band_coef[i] <= BAND_DEF[16*i +: 16];
      end
    end else if (ce_i && wr_i) begin
      if (addr_i >= `TGD_A_TONE_COEF && addr_i < `TGD_A_BAND_A) begin
        tone_coef[4'(addr_i - `TGD_A_TONE_COEF)] <= wdata_i;
      end
      if (addr_i >= `TGD_A_BAND_A && addr_i < 9'(`TGD_A_BAND_B + 9'd10)) begin
        band_coef[5'(addr_i - `TGD_A_BAND_A)] <= wdata_i;
      end
    end
  end

  // Dial timers, on and off reloaded on entering dial mode, pause kept
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dial_on <= `TGD_D_DIAL_TIME;
      dial_off <= `TGD_D_DIAL_TIME;
      dial_pause <= 16'h0000;
    end else if (ce_i) begin
      if (mode_wr && wdata_i[6:0] == `TGD_M_DIAL) begin
        dial_on <= 16'(DIAL_SAMPLES);
        dial_off <= 16'(DIAL_SAMPLES);
      end else if (wr_i && addr_i == `TGD_A_DIAL_ON) begin
        dial_on <= wdata_i;
      end else if (wr_i && addr_i == `TGD_A_DIAL_OFF) begin
        dial_off <= wdata_i;
      end else if (wr_i && addr_i == `TGD_A_DIAL_PAUSE) begin
        dial_pause <= wdata_i;
      end
    end
  end

  // Detector thresholds, restored on entering detect mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      thresh <= `TGD_D_THRESH;
      on_point <= `TGD_D_ON_POINT;
      off_point <= `TGD_D_OFF_POINT;
    end else if (ce_i) begin
      if (mode_wr && wdata_i[6:0] == `TGD_M_DETECT) begin
        thresh <= `TGD_D_THRESH;
        on_point <= `TGD_D_ON_POINT;
        off_point <= `TGD_D_OFF_POINT;
      end else if (wr_i && addr_i == `TGD_A_THRESH) begin
        thresh <= wdata_i;
      end else if (wr_i && addr_i == `TGD_A_ON_POINT) begin
        on_point <= wdata_i;
      end else if (wr_i && addr_i == `TGD_A_OFF_POINT) begin
        off_point <= wdata_i;
      end
    end
  end

  // Discrete detector levels and flags
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tone_flags <= PART_ID;
      for (int i = 0; i < 16; i++) begin
        tone_levels[i] <= 16'h0000;
      end
    end else if (ce_i) begin
      if (mode_wr && wdata_i[6:0] == `TGD_M_STANDBY) begin
        tone_flags <= PART_ID;
      end else if (mode == `TGD_M_DETECT && meas_valid_i) begin
        for (int i = 0; i < 16; i++) begin
          tone_levels[i] <= tone_lev_i[16*i +: 16];
          if (tone_lev_i[16*i +: 16] > thresh) begin
            tone_flags[i] <= 1'b1;
          end else if (tone_lev_i[16*i +: 16] < thresh) begin
            tone_flags[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Band detector hysteresis, bit 1 is detector A
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      band_stat <= 2'b00;
    end else if (ce_i) begin
      if (mode != `TGD_M_DETECT) begin
        band_stat <= 2'b00;
      end else if (meas_valid_i) begin
        if (meas_i.band_a > on_point) begin
          band_stat[1] <= 1'b1;
        end else if (meas_i.band_a < off_point) begin
          band_stat[1] <= 1'b0;
        end
        if (meas_i.band_b > on_point) begin
          band_stat[0] <= 1'b1;
        end else if (meas_i.band_b < off_point) begin
          band_stat[0] <= 1'b0;
        end
      end
    end
  end

  // Eye quality running average and error flag
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      eye_level <= 16'h0000;
      eye_error_o <= 1'b0;
    end else if (ce_i) begin
      if (!eye_mode) begin
        eye_error_o <= 1'b0;
      end else if (meas_valid_i) begin
        eye_level <= 16'($signed({1'b0, eye_level}) + (($signed({1'b0,
          meas_i.mse}) - $signed({1'b0, eye_level})) >>> `TGD_EYE_SHIFT));
        eye_error_o <= eye_level > eye_limit;
      end
    end
  end

  // Dial sequencer next state
  always_comb begin
    next_dial_state = dial_state;
    case (dial_state)
      TGD_IDLE: if (dial_start) next_dial_state = TGD_ON;
      TGD_ON: if (sample_tick_o && dial_cnt <= 16'h0001) begin
        next_dial_state = TGD_OFF;
      end
      TGD_OFF: if (sample_tick_o && dial_cnt <= 16'h0001) begin
        if (!dial_ctrl[`TGD_B_DIAL_PULSE]) next_dial_state = TGD_IDLE;
        else if (pulses <= 4'h1) next_dial_state = TGD_PAUSE;
        else next_dial_state = TGD_ON;
      end
      TGD_PAUSE: if (sample_tick_o && dial_cnt <= 16'h0001) begin
        next_dial_state = TGD_IDLE;
      end
      default: next_dial_state = TGD_IDLE;
    endcase
    if (mode != `TGD_M_DIAL) next_dial_state = TGD_IDLE;
  end

  // Dial sequencer state, interval counter and pulse count
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dial_state <= TGD_IDLE;
      dial_cnt <= 16'h0000;
      pulses <= 4'h0;
    end else if (ce_i) begin
      dial_state <= next_dial_state;
      if (dial_state == TGD_IDLE && next_dial_state == TGD_ON) begin
        pulses <= wdata_i[3:0] == 4'h0 ? 4'hA : wdata_i[3:0];
      end
      if (next_dial_state != dial_state) begin
        case (next_dial_state)
          TGD_ON: dial_cnt <= dial_on;
          TGD_OFF: dial_cnt <= dial_off;
          TGD_PAUSE: dial_cnt <= dial_pause;
          default: dial_cnt <= 16'h0000;
        endcase
        if (dial_state == TGD_OFF) pulses <= pulses - 4'h1;
      end else if (sample_tick_o && dial_cnt != 16'h0000) begin
        dial_cnt <= dial_cnt - 16'h0001;
      end
    end
  end

  assign dial_busy_o = dial_state != TGD_IDLE;
  assign hook_break_o = dial_state == TGD_ON && dial_ctrl[`TGD_B_DIAL_PULSE];
  assign tone_gate = mode == `TGD_M_TONES || (mode == `TGD_M_DIAL
                     && dial_state == TGD_ON
                     && !dial_ctrl[`TGD_B_DIAL_PULSE]);

  // Phase accumulators at the sample rate
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_a <= 16'h0000;
      phase_b <= 16'h0000;
    end else if (ce_i) begin
      if (!tone_gate) begin
        phase_a <= 16'h0000;
        phase_b <= 16'h0000;
      end else if (sample_tick_o) begin
        phase_a <= tgd_step(phase_a, gen_a_step);
        phase_b <= tgd_step(phase_b, gen_b_step);
      end
    end
  end

  // Transmit power taken only at the end of a baud
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_power_live <= `TGD_D_TX_POWER;
    end else if (ce_i && sample_tick_o && baud_cnt == 8'(BAUD_SAMPLES - 1)) begin
      tx_power_live <= tx_power;
    end
  end

  // Mixed output, levels applied on the next cycle
  assign mix = 17'(tgd_gain(tgd_sine(phase_a), low_lev))
             + 17'(tgd_gain(tgd_sine(phase_b), high_lev));
  assign scaled = mix * $signed({1'b0, tx_power_live});
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_o <= 16'sh0000;
    end else if (ce_i) begin
      if (!tone_gate) tx_o <= 16'sh0000;
      else if ($signed(scaled[33:11]) > 23'sh007FFF) tx_o <= 16'sh7FFF;
      else if ($signed(scaled[33:11]) < -23'sh008000) tx_o <= -16'sh8000;
      else tx_o <= scaled[26:11];
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i && rd_i) begin
      rdata_o <= 16'h0000;
      if (addr_i >= `TGD_A_LEVELS && addr_i < 9'(`TGD_A_LEVELS + 9'd16)) begin
        rdata_o <= tone_levels[4'(addr_i - `TGD_A_LEVELS)];
      end
      if (addr_i >= `TGD_A_TONE_COEF && addr_i < `TGD_A_BAND_A) begin
        rdata_o <= tone_coef[4'(addr_i - `TGD_A_TONE_COEF)];
      end
      if (addr_i >= `TGD_A_BAND_A && addr_i < 9'(`TGD_A_BAND_B + 9'd10)) begin
        rdata_o <= band_coef[5'(addr_i - `TGD_A_BAND_A)];
      end
      case (addr_i)
        `TGD_A_FLAGS: rdata_o <= tone_flags;
        `TGD_A_THRESH: rdata_o <= thresh;
        `TGD_A_ON_POINT: rdata_o <= on_point;
        `TGD_A_OFF_POINT: rdata_o <= off_point;
        `TGD_A_EYE_LEVEL: rdata_o <= eye_level;
        `TGD_A_TX_POWER: rdata_o <= tx_power;
        `TGD_A_DIAL_ON: rdata_o <= dial_on;
        `TGD_A_DIAL_OFF: rdata_o <= dial_off;
        `TGD_A_DIAL_PAUSE: rdata_o <= dial_pause;
        `TGD_A_GEN_A: rdata_o <= gen_a_step;
        `TGD_A_GEN_B: rdata_o <= gen_b_step;
        `TGD_A_LOW_LEV: rdata_o <= low_lev;
        `TGD_A_HIGH_LEV: rdata_o <= high_lev;
        `TGD_A_EYE_LIMIT: rdata_o <= eye_limit;
        `TGD_A_MODE: rdata_o <= {9'h000, mode};
        `TGD_A_BAND_STAT: rdata_o <= {band_stat, 14'h0000};
        `TGD_A_DIAL_CTRL: rdata_o <= {dial_ctrl[15:9], dial_busy_o,
                                      dial_ctrl[7:0]};
        `TGD_A_CONNECTION_MODE_REPORT: rdata_o <= (mode >= `TGD_M_V22BIS)
                                     ? {9'h000, mode} : 16'h0000;
        default: ;
      endcase
    end
  end

  // Checks
  a_level_reset: assert property (@(posedge clock_i) rst_i |=> low_lev
    == `TGD_D_LOW_LEV && high_lev == `TGD_D_HIGH_LEV)
    else $error("tone levels not at default after reset");
  a_standby_id: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && mode_wr && wdata_i[6:0] == `TGD_M_STANDBY |=> tone_flags
    == PART_ID)
    else $error("standby did not load part id");
  a_thresh_restore: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && mode_wr && wdata_i[6:0] == `TGD_M_DETECT |=> thresh
    == `TGD_D_THRESH && on_point == `TGD_D_ON_POINT)
    else $error("detect entry did not restore thresholds");
  a_dial_reload: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && mode_wr && wdata_i[6:0] == `TGD_M_DIAL |=> dial_on
    == 16'(DIAL_SAMPLES) && dial_off == 16'(DIAL_SAMPLES))
    else $error("dial timers not reloaded");
  a_phase_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
    {1'b0, phase_a} < `TGD_PH_FULL && {1'b0, phase_b} < `TGD_PH_FULL)
    else $error("phase left its cycle");
  a_standby_quiet: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && mode == `TGD_M_STANDBY |=> tx_o == 16'sh0000 && !dial_busy_o)
    else $error("activity in standby");
  a_power_baud: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && $changed(tx_power_live) |-> $past(sample_tick_o)
    && $past(baud_cnt) == 8'(BAUD_SAMPLES - 1))
    else $error("power changed inside a baud");
  a_level_prompt: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && wr_i && addr_i == `TGD_A_LOW_LEV && mode == `TGD_M_TONES
    |=> low_lev == $past(wdata_i))
    else $error("level write lost");
  a_eye_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !eye_mode |=> !eye_error_o)
    else $error("eye flag outside eye modes");
  a_band_on: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && mode == `TGD_M_DETECT && meas_valid_i
    && meas_i.band_a > on_point && !mode_wr |=> band_stat[1])
    else $error("band A did not set");
  c_tone_mode: cover property (@(posedge clock_i) mode == `TGD_M_TONES
    && tx_o != 16'sh0000);
  c_pulse_pause: cover property (@(posedge clock_i)
    dial_state == TGD_PAUSE);
  c_flag_set: cover property (@(posedge clock_i) mode == `TGD_M_DETECT
    && tone_flags != 16'h0000);
  c_eye_err: cover property (@(posedge clock_i) eye_error_o);
endmodule // tgd_core

//--- tgd_line_model.sv
`timescale 1ns/100ps
// Line side: presents one set of measurements after a chosen lag
module tgd_line_model import tgd_pkg::*; (
  input wire logic clock_i,         // Clock
  input wire logic go_i,            // Request one measurement
  input wire logic [3:0] lag_i,     // Cycles before valid
  input wire tgd_meas_s val_i,      // Values to present
  input wire logic [255:0] lev_i,   // Levels to present
  output tgd_meas_s meas_o,         // Measurement bus
  output logic [255:0] lev_o,       // Detector levels
  output logic valid_o              // Valid pulse
);
  logic [3:0] wait_cnt = '0;
  logic busy = 1'b0;
  initial valid_o = 1'b0;
  initial meas_o = '0;
  initial lev_o = '0;
  // Outside the valid cycle the buses toggle, so stale values never match
  always @(posedge clock_i) begin
    valid_o <= 1'b0;
    meas_o <= ~meas_o;
    lev_o <= ~lev_o;
    if (go_i) begin
      busy <= 1'b1;
      wait_cnt <= lag_i;
    end else if (busy && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      valid_o <= 1'b1;
      meas_o <= val_i;
      lev_o <= lev_i;
    end
  end
endmodule // tgd_line_model

//--- tgd_core_tb_top.sv
`timescale 1ns/100ps
`include "tgd_map.svh"
module tgd_core_tb_top import tgd_pkg::*; ;
  localparam logic [15:0] PART = 16'h5A3C; // Arbitrary value
  localparam logic [95:0] TONE_DEF = `TGD_D_TONE_COEF;
  localparam logic [319:0] BAND_DEF = `TGD_D_BAND_COEF;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, go = 0, rd_d = 0;
  logic [8:0] addr_i = '0;
  logic ce = 1'b1;
  logic [15:0] wdata_i = '0, rdata_o;
  logic signed [15:0] tx_o;
  logic hook_break_o, dial_busy_o, eye_error_o, sample_tick_o, meas_valid;
  logic [3:0] lag = '0;
  tgd_meas_s mval = '0, meas;
  logic [255:0] lval = '0, lev;
  logic [15:0] exp_q[$];
  string name_q[$];
  int failures = 0, samples_checked = 0, seed = 32'h09CA;
  always #50 clock_i = ~clock_i;
  tgd_core #(.BAUD_SAMPLES(4), .PART_ID(PART)) dut (.clock_i(clock_i),
    .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas),
    .tone_lev_i(lev), .meas_valid_i(meas_valid), .tx_o(tx_o),
    .hook_break_o(hook_break_o), .dial_busy_o(dial_busy_o),
    .eye_error_o(eye_error_o), .sample_tick_o(sample_tick_o));
  tgd_line_model line (.clock_i(clock_i), .go_i(go), .lag_i(lag),
    .val_i(mval), .lev_i(lval), .meas_o(meas), .lev_o(lev),
    .valid_o(meas_valid));
  task check(input string what, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask
  task close_out;
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Reads note their expected word; the monitor below compares it
  task rd(input logic [8:0] a, input logic [15:0] e, input string n);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask
  // Read data is compared in the cycle after the strobe
  always @(posedge clock_i) rd_d <= rd_i;
  always @(negedge clock_i) if (rd_d) check(name_q.pop_front(), exp_q.pop_front(), rdata_o);
  task present(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
    int i;
    mval <= {a, b, m};
    lag <= 4'($random(seed) & 7);
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    for (i = 0; i < 20 && meas_valid !== 1'b1; i++) @(negedge clock_i);
    if (i == 20) begin
      check("meas_wait", 16'h0, 16'h1);
      close_out;
    end
    repeat (2) @(posedge clock_i);
  endtask
  task dial(input logic [15:0] ctrl, output int breaks, output int busy);
    int i;
    logic prev;
    breaks = 0;
    busy = 0;
    prev = 0;
    wr(`TGD_A_DIAL_CTRL, ctrl);
    for (i = 0; i < 20000 && (i < 4 || dial_busy_o); i++) begin
      @(negedge clock_i);
      breaks += int'(hook_break_o && !prev);
      busy += int'(dial_busy_o && sample_tick_o);
      prev = hook_break_o;
    end
    if (dial_busy_o) begin
      check("dial_wait", 16'h0, 16'h1);
      close_out;
    end
  endtask
  task watch(output int n);
    n = 0;
    repeat (3000) @(negedge clock_i) n += int'(tx_o != 16'sh0000);
  endtask
  // Main sequence
  initial begin
    logic [6:0] codes[9];
    logic [15:0] thr, mask;
    int i, b, n;
    codes = '{7'h08, 7'h09, 7'h0B, 7'h10, 7'h11, 7'h13,
      7'h14, 7'h20, 7'h21};
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`TGD_A_HIGH_LEV, `TGD_D_HIGH_LEV, "high_band_level");
    rd(`TGD_A_LOW_LEV, `TGD_D_LOW_LEV, "low_band_level");
    rd(`TGD_A_TX_POWER, `TGD_D_TX_POWER, "transmit_power_level");
    rd(9'h100, 16'h0000, "unmapped_word");
    wr(`TGD_A_FLAGS, 16'h0000);
    rd(`TGD_A_FLAGS, PART, "tone_detect_flags");
    for (i = 0; i < 6; i++) rd(`TGD_A_TONE_COEF + 9'(i), TONE_DEF[16*i+:16], "tone_detect_coeffs");
    for (i = 0; i < 20; i++) rd(`TGD_A_BAND_A + 9'(i), BAND_DEF[16*i+:16], "band_coeffs");
    for (i = 0; i < 9; i++) begin
      wr(`TGD_A_MODE, {9'h000, codes[i]});
      rd(`TGD_A_CONNECTION_MODE_REPORT, {9'h000, codes[i]}, "connection_mode_report");
    end
    // Dial mode reloads timers, then pulse and tone dialing
    wr(`TGD_A_DIAL_ON, 16'h0011);
    wr(`TGD_A_MODE, 16'h0003);
    rd(`TGD_A_DIAL_ON, `TGD_D_DIAL_TIME, "dial_on_timer");
    rd(`TGD_A_DIAL_OFF, `TGD_D_DIAL_TIME, "dial_off_timer");
    wr(`TGD_A_DIAL_ON, 16'h0003);
    wr(`TGD_A_DIAL_OFF, 16'h0003);
    wr(`TGD_A_DIAL_PAUSE, 16'h0002);
    dial(16'h0112, b, n);
    check("pulse_breaks", 16'd2, 16'(b));
    check("pulse_ticks", 16'd14, 16'(n));
    dial(16'h0105, b, n);
    check("tone_breaks", 16'd0, 16'(b));
    check("tone_ticks", 16'd6, 16'(n));
    // Detect mode restores thresholds, then random levels
    wr(`TGD_A_THRESH, 16'h0001);
    wr(`TGD_A_ON_POINT, 16'h0001);
    wr(`TGD_A_MODE, 16'h0002);
    rd(`TGD_A_THRESH, `TGD_D_THRESH, "tone_detect_threshold");
    rd(`TGD_A_ON_POINT, `TGD_D_ON_POINT, "band_detect_on_point");
    rd(`TGD_A_OFF_POINT, `TGD_D_OFF_POINT, "band_detect_off_point");
    thr = (16'($random(seed)) & 16'h3FFF) | 16'h0010;
    mask = 16'($random(seed));
    wr(`TGD_A_THRESH, thr);
    for (i = 0; i < 16; i++) lval[16*i+:16] = mask[i] ? thr + 16'h1 : thr - 16'h1;
    present(16'h0300, 16'h0200, 16'h0000);
    rd(`TGD_A_FLAGS, mask, "tone_detect_flags");
    rd(`TGD_A_LEVELS + 9'h005, lval[95:80], "tone_detect_levels");
    rd(`TGD_A_BAND_STAT, 16'h8000, "band_status");
    present(16'h0200, 16'h0300, 16'h0000);
    rd(`TGD_A_BAND_STAT, 16'hC000, "band_status");
    present(16'h0100, 16'h0300, 16'h0000);
    rd(`TGD_A_BAND_STAT, 16'h4000, "band_status");
    wr(`TGD_A_MODE, 16'h0000);
    rd(`TGD_A_FLAGS, PART, "tone_detect_flags");
    // Eye monitor in a data mode
    wr(`TGD_A_MODE, 16'h0008);
    repeat (40) present(16'h0000, 16'h0000, 16'hFFFF);
    check("eye_error", 16'h1, {15'h0, eye_error_o});
    repeat (100) present(16'h0000, 16'h0000, 16'h0000);
    check("eye_error", 16'h0, {15'h0, eye_error_o});
    wr(`TGD_A_TX_POWER, 16'h0400);
    rd(`TGD_A_TX_POWER, 16'h0400, "transmit_power_level");
    // Tone generator: silent with zero levels, active on low level
    wr(`TGD_A_GEN_A, 16'h05FE);
    wr(`TGD_A_LOW_LEV, 16'h0000);
    wr(`TGD_A_HIGH_LEV, 16'h0000);
    wr(`TGD_A_MODE, 16'h0001);
    watch(n);
    check("tx_silent", 16'h0, 16'(n));
    wr(`TGD_A_LOW_LEV, 16'h0287);
    watch(n);
    check("tx_active", 16'h1, {15'h0, n > 0});
    wr(`TGD_A_MODE, 16'h0000);
    repeat (4) @(posedge clock_i);
    watch(n);
    check("tx_standby", 16'h0, 16'(n));
    // A write while the clock enable is low must be lost
    @(posedge clock_i);
    ce <= 1'b0;
    wr(`TGD_A_GEN_B, 16'h1234);
    ce <= 1'b1;
    rd(`TGD_A_GEN_B, 16'h0000, "generator_b_step");
    close_out;
  end
endmodule // tgd_core_tb_top
